// [hdl/wis_cfg.svh]
`ifndef WIS_CFG_SVH
`define WIS_CFG_SVH

// register byte offsets
`define WIS_OFF_CTRL 8'h00
`define WIS_OFF_STATUS 8'h04
`define WIS_OFF_MASK 8'h08
`define WIS_OFF_STRAP 8'h0c
`define WIS_OFF_ENDIAN 8'h10

// control fields
`define WIS_CTRL_WAKE_EN 0
`define WIS_CTRL_POL_HIGH 1
`define WIS_CTRL_PUSH_PULL 2
`define WIS_CTRL_SLEEP 3

// status / mask fields
`define WIS_EVT_WAKE 0
`define WIS_EVT_RESUME 1

// reset values and the fixed endian word
`define WIS_CTRL_RST 4'h0
`define WIS_MASK_RST 2'h0
`define WIS_ENDIAN_VAL 32'h87654321

// synchroniser edges to wait before the strap level is trusted
`define WIS_STRAP_SETTLE 3'h4

// default link settings from the strap: {speed100, full_duplex, autoneg}
`define WIS_LINK_STRAP_HI 3'h7
`define WIS_LINK_STRAP_LO 3'h2

// axi answer codes
`define WIS_RESP_OKAY 2'h0
`define WIS_RESP_SLVERR 2'h2

`endif

// [hdl/wis_pkg.sv]
package wis_pkg;

  typedef enum logic [1:0] {
    WIS_ST_AWAKE,
    WIS_ST_SLEEP
  } wis_pwr_e;

  typedef struct packed {
    logic speed100;
    logic full_duplex;
    logic autoneg;
  } wis_link_s;

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
  } wis_pin_s;

endpackage : wis_pkg

// [hdl/wis_sync.sv]
module wis_sync
  import wis_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // async level
  input wire logic async_i,
  // stable level and change pulse
  output logic level_o,
  output logic change_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic change;
  } wis_sync_s;

  wis_sync_s st_ff;
  wis_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.change = 1'b0;
    // only accept a level once the last two stages agree
    if (st_ff.s2 == st_ff.s3 && st_ff.s3 != st_ff.level) begin
      nxt_st.level = st_ff.s3;
      nxt_st.change = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_o = st_ff.level;
  assign change_o = st_ff.change;

endmodule : wis_sync

// [hdl/wis_top.sv]
// Our own choices: the AXI4-Lite register port and the address map.
`include "wis_cfg.svh"
module wis_top
  import wis_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // host parallel bus strobes (pins)
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  // wake event from detection logic, same clock
  input wire logic wake_event_i,
  // speed strap pin
  input wire logic speed_strap_i,
  // wake request pin
  output logic wake_request_out_o,
  output logic wake_request_out_oe_o,
  // device state
  output logic sleeping_o,
  output wis_link_s link_default_o,
  output logic irq_o,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [1:0] status;
    logic [1:0] mask;
    wis_pwr_e pwr;
    logic wake_req;
    logic strap_taken;
    logic [2:0] strap_wait;
    wis_link_s link;
    logic irq;
  } wis_top_s;

  wis_top_s st_ff;
  wis_top_s nxt_st;

  logic cs_sync;
  logic wr_sync;
  logic strap_sync;
  wis_pin_s wake_pin;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wis_sync u_sync_cs (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(~chip_select_n_i),
    .level_o(cs_sync),
    .change_o()
  );

  wis_sync u_sync_wr (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(~write_strobe_n_i),
    .level_o(wr_sync),
    .change_o()
  );

  wis_sync u_sync_strap (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(speed_strap_i),
    .level_o(strap_sync),
    .change_o()
  );

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] wis_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : wis_merge

  function automatic wis_link_s wis_link_from_strap(input logic strap);
    return strap ? `WIS_LINK_STRAP_HI : `WIS_LINK_STRAP_LO;
  endfunction : wis_link_from_strap

  // one address map for both channels: unmapped offsets answer with an error
  function automatic logic [1:0] wis_resp_for(input logic [7:0] addr);
    logic [1:0] res;
    res = `WIS_RESP_SLVERR;
    unique case (addr)
      `WIS_OFF_CTRL, `WIS_OFF_STATUS, `WIS_OFF_MASK, `WIS_OFF_STRAP, `WIS_OFF_ENDIAN: res = `WIS_RESP_OKAY;
      default: res = `WIS_RESP_SLVERR;
    endcase
    return res;
  endfunction : wis_resp_for

  // read mux; unmapped offsets read as zero
  function automatic logic [31:0] wis_read_data(input logic [7:0] addr, input wis_top_s s);
    logic [31:0] res;
    res = 32'h0;
    unique case (addr)
      `WIS_OFF_CTRL: res = {28'h0, s.ctrl};
      `WIS_OFF_STATUS: res = {30'h0, s.status};
      `WIS_OFF_MASK: res = {30'h0, s.mask};
      `WIS_OFF_STRAP: res = {28'h0, s.pwr == WIS_ST_SLEEP, s.link};
      `WIS_OFF_ENDIAN: res = `WIS_ENDIAN_VAL;
      default: res = 32'h0;
    endcase
    return res;
  endfunction : wis_read_data

  //////////////////////////////////////////////////////////////////////////////
  // next state

  logic do_write;
  logic do_read;
  logic host_write;
  logic [31:0] wr_val;
  logic [1:0] evt;

  always_comb begin
    nxt_st = st_ff;
    evt = 2'h0;
    wr_val = 32'h0;
    // low-active strobes were inverted before the synchroniser, so high means asserted
    host_write = cs_sync & wr_sync;

    // axi address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    // a new write waits until the previous response has been taken
    do_write = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    if (do_write) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wis_resp_for(st_ff.aw_addr);
      wr_val = wis_merge(32'h0, st_ff.w_data, st_ff.w_strb);
      unique case (st_ff.aw_addr)
        `WIS_OFF_CTRL: nxt_st.ctrl = wr_val[3:0];
        `WIS_OFF_STATUS: nxt_st.status = st_ff.status & ~wr_val[1:0];
        `WIS_OFF_MASK: nxt_st.mask = wr_val[1:0];
        // read-only and unmapped offsets change no register
        default: ;
      endcase
    end

    do_read = s_axi_arvalid && s_axi_arready;
    if (do_read) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = wis_resp_for(s_axi_araddr);
      nxt_st.rdata = wis_read_data(s_axi_araddr, st_ff);
    end

    // power state: sleep entered by software, left only by a host write
    unique case (st_ff.pwr)
      WIS_ST_AWAKE: begin
        if (nxt_st.ctrl[`WIS_CTRL_SLEEP] && !st_ff.ctrl[`WIS_CTRL_SLEEP]) begin
          nxt_st.pwr = WIS_ST_SLEEP;
        end
      end
      WIS_ST_SLEEP: begin
        // wake events and the request pin do not change the power state here
        if (host_write) begin
          nxt_st.pwr = WIS_ST_AWAKE;
          nxt_st.ctrl[`WIS_CTRL_SLEEP] = 1'b0;
          nxt_st.wake_req = 1'b0;
          evt[`WIS_EVT_RESUME] = 1'b1;
        end
      end
      default: nxt_st.pwr = WIS_ST_AWAKE;
    endcase

    // request held until the host wakes the device or disables signalling
    if (wake_event_i && st_ff.ctrl[`WIS_CTRL_WAKE_EN] && st_ff.pwr == WIS_ST_SLEEP) begin
      nxt_st.wake_req = 1'b1;
      evt[`WIS_EVT_WAKE] = 1'b1;
    end
    if (!st_ff.ctrl[`WIS_CTRL_WAKE_EN]) begin
      nxt_st.wake_req = 1'b0;
    end

    // set wins over a clear in the same cycle
    nxt_st.status = nxt_st.status | evt;

    // strap caught once the synchroniser has passed on the level seen at reset release;
    // taking it on the first edge would read the synchroniser's reset value instead
    if (!st_ff.strap_taken) begin
      if (st_ff.strap_wait == `WIS_STRAP_SETTLE) begin
        nxt_st.strap_taken = 1'b1;
        nxt_st.link = wis_link_from_strap(strap_sync);
      end else begin
        nxt_st.strap_wait = st_ff.strap_wait + 3'h1;
      end
    end

    // taken from the next state so irq_o moves on the same edge as the status bits
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
      st_ff.ctrl <= `WIS_CTRL_RST;
      st_ff.mask <= `WIS_MASK_RST;
      st_ff.pwr <= WIS_ST_AWAKE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wake pin driver

  // registered so the pin cannot glitch while the mode bits change
  wis_wake_pin u_wake_pin (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .request_i(st_ff.wake_req),
    .pol_high_i(st_ff.ctrl[`WIS_CTRL_POL_HIGH]),
    .push_pull_i(st_ff.ctrl[`WIS_CTRL_PUSH_PULL]),
    .pin_o(wake_pin)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wake_request_out_o = wake_pin.pin_o;
  assign wake_request_out_oe_o = wake_pin.pin_oe;
  assign sleeping_o = st_ff.pwr == WIS_ST_SLEEP;
  assign link_default_o = st_ff.link;
  assign irq_o = st_ff.irq;
  assign s_axi_awready = !st_ff.aw_held;
  assign s_axi_wready = !st_ff.w_held;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  // one read in flight: no new address while data waits
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

endmodule : wis_top

// [hdl/wis_wake_pin.sv]
`include "wis_cfg.svh"
module wis_wake_pin
  import wis_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic request_i,
  input wire logic pol_high_i,
  input wire logic push_pull_i,
  // pin
  output wis_pin_s pin_o
);

  wis_pin_s st_ff;
  wis_pin_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (push_pull_i) begin
      nxt_st.pin_oe = 1'b1;
      nxt_st.pin_o = request_i ~^ pol_high_i ? 1'b1 : 1'b0;
    end else begin
      // open drain can only pull low; active-high polarity then relies on the pull-up
      nxt_st.pin_o = 1'b0;
      nxt_st.pin_oe = pol_high_i ? ~request_i : request_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_o = st_ff;

endmodule : wis_wake_pin

// [verif/wake_indicator_and_speed_strap_test.sv]
`include "wis_cfg.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module wake_indicator_and_speed_strap_test;
  import wis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  int bad_count = 0;
  int n_compared = 0;
  logic clk, rst, wake_event, strap, pin, oe, sleeping, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  wis_link_s link;
  wire logic cs_n;
  wire logic wr_n;
  always #4 clk = ~clk;
  wis_host_model host (.core_clk_i(clk), .chip_select_n_o(cs_n), .write_strobe_n_o(wr_n));
  wis_top dut (.core_clk_i(clk), .sys_rst_i(rst), .chip_select_n_i(cs_n), .write_strobe_n_i(wr_n),
    .wake_event_i(wake_event), .speed_strap_i(strap), .wake_request_out_o(pin), .wake_request_out_oe_o(oe),
    .sleeping_o(sleeping), .link_default_o(link), .irq_o(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // readies are flop driven, so the value at the falling edge is what the next rising edge sees
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 50 && !b_t; n++) begin
      @(negedge clk);
      aw_t = (awready === 1'b1);
      w_t = (wready === 1'b1);
      b_t = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    if (!b_t) begin
      bad_count++;
      finish_test();
    end
    `CHK(r, er)
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    r_t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; n < 50 && !r_t; n++) begin
      @(negedge clk);
      ar_t = (arready === 1'b1);
      r_t = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end
    if (!r_t) begin
      bad_count++;
      finish_test();
    end
    `CHK(d, ed)
    `CHK(r, er)
  endtask : axi_rd
  task automatic pulse_event();
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse_event
  ////////////////////////////////////////////////////////////
  task automatic t_strap();
    repeat (8) @(posedge clk);
    `CHK(link, `WIS_LINK_STRAP_HI)
    strap <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(link, `WIS_LINK_STRAP_HI)
  endtask : t_strap
  task automatic t_regs();
    axi_rd(`WIS_OFF_CTRL, 32'h0, `WIS_RESP_OKAY);
    axi_rd(`WIS_OFF_MASK, 32'h0, `WIS_RESP_OKAY);
    axi_rd(`WIS_OFF_ENDIAN, `WIS_ENDIAN_VAL, `WIS_RESP_OKAY);
    axi_rd(`WIS_OFF_STRAP, {29'h0, `WIS_LINK_STRAP_HI}, `WIS_RESP_OKAY);
    axi_rd(8'h20, 32'h0, `WIS_RESP_SLVERR);
    axi_wr(8'h20, 32'h0, `WIS_RESP_SLVERR);
  endtask : t_regs
  task automatic t_wake_pp();
    axi_wr(`WIS_OFF_CTRL, 32'hf, `WIS_RESP_OKAY);
    pulse_event();
    `CHK(pin, 1'b1)
    `CHK(oe, 1'b1)
    repeat (10) @(posedge clk);
    `CHK(sleeping, 1'b1)
    axi_rd(`WIS_OFF_STATUS, 32'h1, `WIS_RESP_OKAY);
    `CHK(irq, 1'b0)
    axi_wr(`WIS_OFF_MASK, 32'h1, `WIS_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    axi_wr(`WIS_OFF_STATUS, 32'h1, `WIS_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    host.cycle(1'b0);
    `CHK(sleeping, 1'b1)
    host.cycle(1'b1);
    repeat (4) @(posedge clk);
    `CHK(sleeping, 1'b0)
    `CHK(pin, 1'b0)
    axi_rd(`WIS_OFF_STATUS, 32'h2, `WIS_RESP_OKAY);
  endtask : t_wake_pp
  task automatic t_wake_od();
    axi_wr(`WIS_OFF_CTRL, 32'h9, `WIS_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(oe, 1'b0)
    pulse_event();
    `CHK(oe, 1'b1)
    `CHK(pin, 1'b0)
    host.cycle(1'b1);
    repeat (4) @(posedge clk);
    `CHK(sleeping, 1'b0)
    `CHK(oe, 1'b0)
    axi_wr(`WIS_OFF_CTRL, 32'h5, `WIS_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(pin, 1'b1)
    `CHK(oe, 1'b1)
    axi_wr(`WIS_OFF_CTRL, 32'h3, `WIS_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(oe, 1'b1)
    `CHK(pin, 1'b0)
  endtask : t_wake_od
  task automatic t_wake_off();
    axi_wr(`WIS_OFF_CTRL, 32'hf, `WIS_RESP_OKAY);
    pulse_event();
    `CHK(pin, 1'b1)
    axi_wr(`WIS_OFF_CTRL, 32'he, `WIS_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK(pin, 1'b0)
    `CHK(sleeping, 1'b1)
    host.cycle(1'b1);
    repeat (4) @(posedge clk);
    `CHK(sleeping, 1'b0)
  endtask : t_wake_off
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    strap = 1'b1;
    wake_event = 1'b0;
    {awvalid, wvalid, arvalid} = 3'h0;
    // response readies stay high, so each answer is taken on the first edge after it shows
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_strap();
    t_regs();
    t_wake_pp();
    t_wake_od();
    t_wake_off();
    finish_test();
  end
endmodule : wake_indicator_and_speed_strap_test

// [verif/wis_host_model.sv]
module wis_host_model (
  // clock
  input wire logic core_clk_i,
  // host strobes, active low
  output logic chip_select_n_o,
  output logic write_strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n_o = 1'b1;
    write_strobe_n_o = 1'b1;
  end
  // held 8 cycles so the device's pin synchroniser surely sees it
  task automatic cycle(input logic is_write);
    @(posedge core_clk_i);
    chip_select_n_o <= 1'b0;
    write_strobe_n_o <= !is_write;
    repeat (8) @(posedge core_clk_i);
    chip_select_n_o <= 1'b1;
    write_strobe_n_o <= 1'b1;
    @(posedge core_clk_i);
  endtask : cycle
endmodule : wis_host_model

// [verif/wis_top_checker.sv]
`include "wis_cfg.svh"
module wis_top_checker
  import wis_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic wake_event_i,
  input wire logic speed_strap_i,
  input wire logic wake_request_out_o,
  input wire logic wake_request_out_oe_o,
  input wire logic sleeping_o,
  input wire wis_link_s link_default_o,
  // axi write
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ctrl_ff;
  logic [2:0] rst_cnt_ff;
  logic [3:0] idle_ff;
  logic strap_ff;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////
  // shadow only follows writes taken on one edge, as the bench offers them
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_ff <= 3'h0;
      rst_cnt_ff <= 3'h0;
      idle_ff <= 4'hf;
    end else begin
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `WIS_OFF_CTRL) begin
        ctrl_ff <= s_axi_wdata[2:0];
      end
      rst_cnt_ff <= (rst_cnt_ff == 3'h7) ? rst_cnt_ff : rst_cnt_ff + 3'h1;
      idle_ff <= (!chip_select_n_i && !write_strobe_n_i) ? 4'h0 : ((idle_ff == 4'hf) ? idle_ff : idle_ff + 4'h1);
    end
  end
  // keeps the last strap level seen while reset is held
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      strap_ff <= speed_strap_i;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence pin_write;
    (!chip_select_n_i && !write_strobe_n_i) [*2];
  endsequence
  sequence asleep_event;
    sleeping_o && wake_event_i;
  endsequence
  AST_WAKE_PP: assert property (ctrl_ff == 3'h7 ##0 asleep_event |-> ##[1:3] wake_request_out_o)
    else $error("wake pin not raised after wake event");
  AST_WAKE_OD: assert property (ctrl_ff == 3'h1 ##0 asleep_event |-> ##[1:3] wake_request_out_oe_o)
    else $error("open drain wake pin not pulled after wake event");
  AST_PP_DRIVE: assert property (ctrl_ff[2] && $past(ctrl_ff[2], 2) |-> wake_request_out_oe_o)
    else $error("push pull wake pin not driven");
  AST_OD_LOW: assert property (!ctrl_ff[2] && !$past(ctrl_ff[2], 2) |-> !wake_request_out_o)
    else $error("open drain wake pin drives high");
  AST_NO_SELF_WAKE: assert property (sleeping_o && idle_ff == 4'hf && !s_axi_awvalid |=> sleeping_o)
    else $error("sleep left without a host write");
  AST_WAKE_CAUSE: assert property ($fell(sleeping_o) |-> idle_ff < 4'h8)
    else $error("sleep left with no recent write cycle");
  AST_WRITE_WAKES: assert property (sleeping_o ##0 pin_write |-> ##[1:7] !sleeping_o)
    else $error("host write did not wake the device");
  AST_STRAP_HELD: assert property (rst_cnt_ff == 3'h7 |-> $stable(link_default_o))
    else $error("link default changed after reset");
  AST_STRAP_MAP: assert property (rst_cnt_ff == 3'h7 |->
    link_default_o == wis_link_s'(strap_ff ? `WIS_LINK_STRAP_HI : `WIS_LINK_STRAP_LO))
    else $error("link default does not match strap");
endmodule : wis_top_checker

bind wis_top wis_top_checker u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .chip_select_n_i(chip_select_n_i), .write_strobe_n_i(write_strobe_n_i), .wake_event_i(wake_event_i),
  .speed_strap_i(speed_strap_i), .wake_request_out_o(wake_request_out_o),
  .wake_request_out_oe_o(wake_request_out_oe_o), .sleeping_o(sleeping_o), .link_default_o(link_default_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata));
